// >>> pmr_consts.svh
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH

// Register indices on the management bus.
`define PMR_OFS_SMCFG      5'h09
`define PMR_OFS_IACTL      5'h0d
`define PMR_OFS_IADATA     5'h0e
`define PMR_OFS_INTTEST    5'h11

// Serial MAC configuration fields.
`define PMR_SM_SRST_BIT    15
`define PMR_SM_TXED_BIT    14
`define PMR_SM_ANEN_BIT    13
`define PMR_SM_EN_BIT      12
`define PMR_SM_TDRA_BIT    8
`define PMR_SM_RST_VAL     16'h2000

// Indirect control fields.
`define PMR_IA_CMD_HI      15
`define PMR_IA_CMD_LO      14
`define PMR_IA_DEV_HI      4
`define PMR_IA_DEV_LO      0
`define PMR_IA_RST_VAL     16'h0000
`define PMR_IA_WMASK       16'hc01f
`define PMR_DEV_VENDOR     5'h1f
`define PMR_DEV_MMD1       5'h01
`define PMR_VENDOR_TOP     16'h04d1

// Interrupt test fields.
`define PMR_IT_POL_BIT     3
`define PMR_IT_TEST_BIT    2
`define PMR_IT_RST_VAL     16'h010b

`endif

// >>> pmr_mmd_if.sv
`timescale 1ns/1ps

interface pmr_mmd_if;
  logic        wrEn;
  logic        rdEn;
  logic        isVendor;
  logic [15:0] addr;
  logic [15:0] wrData;
  logic [15:0] rdData;

  modport ctrl
  (
    output wrEn,
    output rdEn,
    output isVendor,
    output addr,
    output wrData,
    input  rdData
  );

  modport space
  (
    input  wrEn,
    input  rdEn,
    input  isVendor,
    input  addr,
    input  wrData,
    output rdData
  );
endinterface : pmr_mmd_if

// >>> pmr_mmd_space.sv
`timescale 1ns/1ps
`include "pmr_consts.svh"

// Small stand-in storage for the two indirect spaces, indexed by low address bits.
module pmr_mmd_space
  import pmr_pkg::*;
#(
  parameter int AW = 4
)
(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Indirect access port.
  pmr_mmd_if.space mmd
);

  logic [15:0] vendMem [2**AW];
  logic [15:0] mmd1Mem [2**AW];
  logic [AW-1:0] idx;
  logic          inRange;

  assign idx     = mmd.addr[AW-1:0];
  // Vendor space ends at its top address; above it the space is empty.
  assign inRange = !mmd.isVendor || (mmd.addr <= `PMR_VENDOR_TOP);

  always_ff @(posedge core_clk)
  begin
    if (mmd.wrEn && inRange && mmd.isVendor)
      vendMem[idx] <= mmd.wrData;
    if (mmd.wrEn && !mmd.isVendor)
      mmd1Mem[idx] <= mmd.wrData;
  end

  always_comb
  begin
    if (!inRange)
      mmd.rdData = 16'h0000;
    else if (mmd.isVendor)
      mmd.rdData = vendMem[idx];
    else
      mmd.rdData = mmd1Mem[idx];
  end

endmodule : pmr_mmd_space

// >>> pmr_pkg.sv
package pmr_pkg;

  typedef enum logic [1:0]
  {
    PMR_CMD_ADDR   = 2'h0,
    PMR_CMD_DATA   = 2'h1,
    PMR_CMD_INC_RW = 2'h2,
    PMR_CMD_INC_W  = 2'h3
  } pmr_cmd_t;

endpackage : pmr_pkg

// >>> pmr_regs.sv
`timescale 1ns/1ps
`include "pmr_consts.svh"

module pmr_regs
  import pmr_pkg::*;
#(
  parameter int MMD_AW = 4
)
(
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Strap sampled after reset release.
  input  wire logic        strapSmEnable,
  // Register port from the management frame decoder.
  input  wire logic [4:0]  regAddr,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [15:0] regWrData,
  output logic      [15:0] regRdData,
  // Serial MAC interface controls.
  output logic             smSoftResetPulse,
  output logic             smTxErrEnable,
  output logic             smAutoNegEnable,
  output logic             smEnable,
  // Cable diagnostics.
  input  wire logic        linkUp,
  output logic             tdrStart,
  // Interrupt pin.
  input  wire logic        intEvent,
  output logic             intPin
);

  logic [15:0] smCfg_r, smCfg_nxt;
  logic [15:0] iaCtl_r, iaCtl_nxt;
  logic [15:0] mmdAddrV_r, mmdAddrV_nxt;
  logic [15:0] mmdAddr1_r, mmdAddr1_nxt;
  logic [15:0] itReg_r, itReg_nxt;
  logic        strapDone_r, strapDone_nxt;
  logic        linkUp_r, linkUp_nxt;
  logic        srstPulse_r, srstPulse_nxt;
  logic        tdrStart_r, tdrStart_nxt;
  logic [15:0] rdData_r, rdData_nxt;
  logic        intPin_r, intPin_nxt;

  pmr_mmd_if mmd ();

  pmr_cmd_t    cmd;
  logic [4:0]  devCode;
  logic        devVendor;
  logic        devMmd1;
  logic        devValid;
  logic [15:0] curAddr;
  logic        iaWr;
  logic        iaRd;
  logic        dataMode;
  logic        incNow;
  logic        intActive;

  assign cmd       = pmr_cmd_t'(iaCtl_r[`PMR_IA_CMD_HI:`PMR_IA_CMD_LO]);
  assign devCode   = iaCtl_r[`PMR_IA_DEV_HI:`PMR_IA_DEV_LO];
  assign devVendor = (devCode == `PMR_DEV_VENDOR);
  assign devMmd1   = (devCode == `PMR_DEV_MMD1);
  assign devValid  = devVendor || devMmd1;
  assign curAddr   = devVendor ? mmdAddrV_r : mmdAddr1_r;
  assign iaWr      = regWr && (regAddr == `PMR_OFS_IADATA) && devValid;
  assign iaRd      = regRd && (regAddr == `PMR_OFS_IADATA) && devValid;
  assign dataMode  = (cmd != PMR_CMD_ADDR);

  // Post-increment decision per command code.
  always_comb
  begin
    unique case (cmd)
      PMR_CMD_ADDR:   incNow = 1'b0;
      PMR_CMD_DATA:   incNow = 1'b0;
      PMR_CMD_INC_RW: incNow = iaWr || iaRd;
      PMR_CMD_INC_W:  incNow = iaWr;
    endcase
  end

  assign mmd.wrEn     = iaWr && dataMode;
  assign mmd.rdEn     = iaRd && dataMode;
  assign mmd.isVendor = devVendor;
  assign mmd.addr     = curAddr;
  assign mmd.wrData   = regWrData;

  pmr_mmd_space #(
    .AW (MMD_AW)
  ) u_space (
    .core_clk (core_clk),
    .rst      (rst),
    .mmd      (mmd)
  );

  // Register writes and the address pointers.
  always_comb
  begin
    smCfg_nxt     = smCfg_r;
    iaCtl_nxt     = iaCtl_r;
    mmdAddrV_nxt  = mmdAddrV_r;
    mmdAddr1_nxt  = mmdAddr1_r;
    itReg_nxt     = itReg_r;
    strapDone_nxt = 1'b1;
    srstPulse_nxt = 1'b0;
    // The strap is caught on the first clock after release, not under reset.
    if (!strapDone_r)
      smCfg_nxt[`PMR_SM_EN_BIT] = strapSmEnable;
    // Soft reset self-clears one cycle after the write, making a one-cycle pulse.
    if (smCfg_r[`PMR_SM_SRST_BIT])
    begin
      smCfg_nxt[`PMR_SM_SRST_BIT] = 1'b0;
      srstPulse_nxt               = 1'b1;
    end
    if (regWr)
    begin
      unique case (regAddr)
        `PMR_OFS_SMCFG:   smCfg_nxt = regWrData;
        `PMR_OFS_IACTL:   iaCtl_nxt = regWrData & `PMR_IA_WMASK;
        `PMR_OFS_INTTEST: itReg_nxt = regWrData;
        default:          ;
      endcase
    end
    // Address mode loads the selected pointer.
    if (iaWr && !dataMode)
    begin
      if (devVendor)
        mmdAddrV_nxt = regWrData;
      else
        mmdAddr1_nxt = regWrData;
    end
    if (incNow)
    begin
      if (devVendor)
        mmdAddrV_nxt = mmdAddrV_r + 16'h0001;
      else
        mmdAddr1_nxt = mmdAddr1_r + 16'h0001;
    end
  end

  // Read mux, registered one cycle after the read strobe.
  always_comb
  begin
    rdData_nxt = rdData_r;
    if (regRd)
    begin
      unique case (regAddr)
        `PMR_OFS_SMCFG:   rdData_nxt = smCfg_r;
        `PMR_OFS_IACTL:   rdData_nxt = iaCtl_r;
        `PMR_OFS_IADATA:
        begin
          if (!devValid)
            rdData_nxt = 16'h0000;
          else if (dataMode)
            rdData_nxt = mmd.rdData;
          else
            rdData_nxt = curAddr;
        end
        `PMR_OFS_INTTEST: rdData_nxt = itReg_r;
        default:          rdData_nxt = 16'h0000;
      endcase
    end
  end

  // Link loss detection and the interrupt pin.
  always_comb
  begin
    linkUp_nxt   = linkUp;
    tdrStart_nxt = smCfg_r[`PMR_SM_TDRA_BIT] && linkUp_r && !linkUp;
    intActive    = intEvent || itReg_r[`PMR_IT_TEST_BIT];
    intPin_nxt   = itReg_r[`PMR_IT_POL_BIT] ? !intActive : intActive;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      smCfg_r     <= `PMR_SM_RST_VAL;
      iaCtl_r     <= `PMR_IA_RST_VAL;
      mmdAddrV_r  <= 16'h0000;
      mmdAddr1_r  <= 16'h0000;
      itReg_r     <= `PMR_IT_RST_VAL;
      strapDone_r <= 1'b0;
      linkUp_r    <= 1'b0;
      srstPulse_r <= 1'b0;
      tdrStart_r  <= 1'b0;
      rdData_r    <= 16'h0000;
      intPin_r    <= 1'b1;
    end
    else
    begin
      smCfg_r     <= smCfg_nxt;
      iaCtl_r     <= iaCtl_nxt;
      mmdAddrV_r  <= mmdAddrV_nxt;
      mmdAddr1_r  <= mmdAddr1_nxt;
      itReg_r     <= itReg_nxt;
      strapDone_r <= strapDone_nxt;
      linkUp_r    <= linkUp_nxt;
      srstPulse_r <= srstPulse_nxt;
      tdrStart_r  <= tdrStart_nxt;
      rdData_r    <= rdData_nxt;
      intPin_r    <= intPin_nxt;
    end
  end

  assign regRdData        = rdData_r;
  assign smSoftResetPulse = srstPulse_r;
  assign smTxErrEnable    = !smCfg_r[`PMR_SM_TXED_BIT];
  assign smAutoNegEnable  = smCfg_r[`PMR_SM_ANEN_BIT];
  assign smEnable         = smCfg_r[`PMR_SM_EN_BIT];
  assign tdrStart         = tdrStart_r;
  assign intPin           = intPin_r;

endmodule : pmr_regs

// >>> pmr_regs_checker.sv
`timescale 1ns/1ps

module pmr_regs_checker
(
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        rst,
  // Register port.
  input wire logic [4:0]  regAddr,
  input wire logic        regWr,
  input wire logic [15:0] regWrData,
  // Block outputs and side inputs.
  input wire logic        smSoftResetPulse,
  input wire logic        smTxErrEnable,
  input wire logic        smAutoNegEnable,
  input wire logic        smEnable,
  input wire logic        linkUp,
  input wire logic        tdrStart,
  input wire logic        intEvent,
  input wire logic        intPin
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);

  // Shadow of auto-run, polarity and test bits, rebuilt from the writes seen on the port.
  logic [2:0] sh_r;
  logic [2:0] sh_nxt;
  logic       wSm;
  assign wSm = regWr && regAddr == 5'h09;

  always_comb
  begin
    sh_nxt = sh_r;
    if (wSm)
      sh_nxt[2] = regWrData[8];
    if (regWr && regAddr == 5'h11)
      sh_nxt[1:0] = regWrData[3:2];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      sh_r <= 3'h2;
    else
      sh_r <= sh_nxt;
  end

  property p_srst;
    wSm && regWrData[15] |-> ##[1:2] smSoftResetPulse;
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset pulse missing");
  property p_pul;
    smSoftResetPulse |=> !smSoftResetPulse;
  endproperty
  a_pul: assert property (p_pul) else $error("soft reset pulse too long");
  property p_txe;
    wSm |=> smTxErrEnable == !$past(regWrData[14]);
  endproperty
  a_txe: assert property (p_txe) else $error("tx error enable wrong");
  property p_an;
    wSm |=> smAutoNegEnable == $past(regWrData[13]);
  endproperty
  a_an: assert property (p_an) else $error("autoneg enable wrong");
  property p_en;
    wSm |=> smEnable == $past(regWrData[12]);
  endproperty
  a_en: assert property (p_en) else $error("interface enable wrong");
  property p_tdr;
    $fell(linkUp) && sh_r[2] |=> tdrStart;
  endproperty
  a_tdr: assert property (p_tdr) else $error("diagnostic start missing");
  property p_tdroff;
    !sh_r[2] |=> !tdrStart;
  endproperty
  a_tdroff: assert property (p_tdroff) else $error("diagnostic start without auto-run");
  property p_int;
    intPin == $past(sh_r[1] ^ (intEvent | sh_r[0]));
  endproperty
  a_int: assert property (p_int) else $error("interrupt pin level wrong");
  property p_tst;
    sh_r[0] |=> intPin == !$past(sh_r[1]);
  endproperty
  a_tst: assert property (p_tst) else $error("forced interrupt missing");
endmodule : pmr_regs_checker

bind pmr_regs pmr_regs_checker i_pmr_regs_checker (.*);

// >>> pmr_regs_tb.sv
`timescale 1ns/1ps

module pmr_regs_tb
  import pmr_pkg::*;
;
  logic        core_clk, rst, strapSmEnable, linkUp, intEvent, regWr, regRd, rdSeen;
  logic        smSoftResetPulse, smTxErrEnable, smAutoNegEnable, smEnable, tdrStart, intPin;
  logic [4:0]  regAddr, dv;
  logic [15:0] regWrData, regRdData, v0, v1, expV;
  logic [15:0] expQ[$];
  int          mismatches, checks_done, seed;

  pmr_regs #(.MMD_AW(4)) i_pmr_regs (.*);
  pmr_smc_model i_pmr_smc_model (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    i_pmr_smc_model.op(1'b1, 1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    expQ.push_back(e);
    i_pmr_smc_model.op(1'b0, 1'b1, a, 16'h0000);
  endtask : rd

  // Idle data is inverted so a stale value is never mistaken for a held one.
  task automatic idle(input int n);
    repeat (n) i_pmr_smc_model.op(1'b0, 1'b0, 5'h00, ~regWrData);
  endtask : idle

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  always @(posedge core_clk)
  begin
    if (rdSeen)
    begin
      expV = expQ.pop_front();
      checks_done++;
      if (regRdData !== expV)
      begin
        mismatches++;
        $display("unexpected at %0t: got %h expected %h", $time, regRdData, expV);
      end
    end
    rdSeen <= regRd;
  end

  initial
  begin
    seed = 32'ha87cfa48;
    rst = 1'b1;
    strapSmEnable = 1'b1;
    linkUp = 1'b1;
    intEvent = 1'b0;
    rdSeen = 1'b0;
    mismatches = 0;
    checks_done = 0;
    repeat (3) @(posedge core_clk);
    #1;
    rst = 1'b0;
    idle(2);
    rd(5'h09, 16'h3000);
    rd(5'h0d, 16'h0000);
    rd(5'h11, 16'h010b);
    rd(5'h05, 16'h0000);
    $display("reset values done");
    v0 = $random(seed) & 16'h7fff;
    wr(5'h09, v0);
    rd(5'h09, v0);
    wr(5'h09, v0 | 16'h8000);
    idle(2);
    rd(5'h09, v0);
    wr(5'h09, 16'h0100);
    linkUp = 1'b0;
    idle(2);
    linkUp = 1'b1;
    wr(5'h09, 16'h0000);
    linkUp = 1'b0;
    idle(2);
    linkUp = 1'b1;
    $display("serial config done");
    for (int i = 0; i < 2; i++)
    begin
      dv = i ? 5'h01 : 5'h1f;
      v0 = $random(seed);
      v1 = $random(seed);
      wr(5'h0d, {PMR_CMD_ADDR, 9'h000, dv});
      wr(5'h0e, 16'h0002);
      wr(5'h0d, {PMR_CMD_INC_RW, 9'h000, dv});
      wr(5'h0e, v0);
      wr(5'h0e, v1);
      wr(5'h0d, {PMR_CMD_ADDR, 9'h000, dv});
      rd(5'h0e, 16'h0004);
      wr(5'h0e, 16'h0002);
      wr(5'h0d, {PMR_CMD_DATA, 9'h000, dv});
      rd(5'h0e, v0);
      rd(5'h0e, v0);
      wr(5'h0d, {PMR_CMD_INC_W, 9'h000, dv});
      rd(5'h0e, v0);
      wr(5'h0e, v0);
      rd(5'h0e, v1);
      wr(5'h0d, {PMR_CMD_INC_RW, 9'h000, dv});
      rd(5'h0e, v1);
      wr(5'h0d, {PMR_CMD_ADDR, 9'h000, dv});
      rd(5'h0e, 16'h0004);
    end
    wr(5'h0d, 16'h0002);
    wr(5'h0e, 16'h1234);
    rd(5'h0e, 16'h0000);
    wr(5'h0d, 16'h0001);
    rd(5'h0e, 16'h0004);
    wr(5'h0d, 16'hffff);
    rd(5'h0d, 16'hc01f);
    $display("indirect access done");
    for (int k = 0; k < 4; k++)
    begin
      v0 = $random(seed);
      intEvent = v0[0];
      wr(5'h11, {12'h010, k[1:0], 2'h3});
      rd(5'h11, {12'h010, k[1:0], 2'h3});
      idle(2);
    end
    intEvent = 1'b0;
    $display("interrupt test done");
    idle(2);
    end_sim();
  end

  initial
  begin
    #(25 * 1000);
    mismatches++;
    end_sim();
  end
endmodule : pmr_regs_tb

// >>> pmr_smc_model.sv
`timescale 1ns/1ps

module pmr_smc_model
(
  // Clock.
  input wire logic   core_clk,
  // Register port.
  output logic [4:0]  regAddr,
  output logic        regWr,
  output logic        regRd,
  output logic [15:0] regWrData
);
  initial
  begin
    regAddr = 5'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    regWrData = 16'h0000;
  end

  // Strobes are left up so calls may follow back to back without a glitch.
  task automatic op(input logic w, input logic r, input logic [4:0] a, input logic [15:0] d);
    regWr = w;
    regRd = r;
    regAddr = a;
    regWrData = d;
    @(posedge core_clk);
    #1;
  endtask : op
endmodule : pmr_smc_model
